// ==== verilog/lcm_pkg.sv ====
// Functional notes
// R1: contrast register bits 7:5 always read 000 and software must write 000 to them.
// R2: contrast bits 4:0 are the supply regulator setpoint code, 00000 lowest (1.90 V) to 11111 highest (3.72 V).
// R3: contrast register sits at page 0x2 address 0x9C, master control at page 0x2 address 0xAB.
// R4: master control bits 7 and 3 always read 0 and software must write 0 to them.
// R5: master control bit 6 enables the display bias generator and resets to 0.
// R6: software may clear bias enable only for static drive, bypass contrast mode and a disabled supply comparator.
// R7: master control bit 5 routes bias to the converter when 1 and resets to 1.
// R8: the shared bias generator runs whenever either the display or the converter asks for bias.
// R9: master control bit 4 passes the undivided low-frequency clock to the display when 1, blocks it when 0.
// R10: master control bit 2 selects reduced charge pump drive when 1 and full drive when 0.
// R11: writing 1 to master control bit 1 forces every segment data register to 0x00.
// R12: the segment data clear bit does not clear itself; software writes it back to 0.
// R13: master control bit 0 turns the display module on when 1 and resets to 0.
// R14: each segment data register holds two 4-bit groups, one per display pin.
// R15: the gated clock is divided by 1, 2 or 4 for divider codes 00, 01, 10; code 11 is reserved.
// R16: while the clear bit reads 1 all segment data registers are held at zero and writes to them do not stick.
// R17: reserved bits are constant zero and writes to them are ignored.
`default_nettype none
package lcm_pkg;

    localparam logic [7:0] LCM_SFR_PAGE        = 8'h02;
    localparam logic [7:0] LCM_CONTRAST_ADDR   = 8'h9C;
    localparam logic [7:0] LCM_MASTER_ADDR     = 8'hAB;
    localparam logic [7:0] LCM_SEG_BASE_ADDR   = 8'h89;
    localparam int         LCM_SEG_REGS        = 16;
    localparam int         LCM_SEG_IDX_W       = 4;

    // contrast register layout
    localparam logic [7:0] LCM_CONTRAST_MASK   = 8'h1F;
    localparam logic [4:0] LCM_CONTRAST_RST    = 5'h00;

    // master control bit positions
    localparam int         LCM_MC_BIAS_EN      = 6;
    localparam int         LCM_MC_CONV_OE      = 5;
    localparam int         LCM_MC_CLK_GATE     = 4;
    localparam int         LCM_MC_LOW_DRV      = 2;
    localparam int         LCM_MC_SEG_CLR      = 1;
    localparam int         LCM_MC_MOD_EN       = 0;
    localparam logic [7:0] LCM_MASTER_MASK     = 8'h77;
    localparam logic [7:0] LCM_MASTER_RST      = 8'h20;

    // clock divider codes
    localparam logic [1:0] LCM_DIV1            = 2'h0;
    localparam logic [1:0] LCM_DIV2            = 2'h1;
    localparam logic [1:0] LCM_DIV4            = 2'h2;

    typedef struct packed {
        logic [7:0] page;
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } lcm_sfr_req_t;

    typedef struct packed {
        logic [4:0] contrastCode;
        logic       biasGeneratorOn;
        logic       displayBiasEnable;
        logic       converterBiasOutputEnable;
        logic       pumpReducedDrive;
        logic       displayModuleEnable;
        logic       segmentDataClear;
    } lcm_ctrl_t;

endpackage
`default_nettype wire

// ==== verilog/lcm_seg_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcm_seg_mem (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             sys_rst,
    // write port
    input  wire logic                             wrEn,
    input  wire logic [lcm_pkg::LCM_SEG_IDX_W-1:0] wrIdx,
    input  wire logic [7:0]                       wrData,
    input  wire logic                             clearAll,
    // stored contents, one byte per register
    output logic [8*lcm_pkg::LCM_SEG_REGS-1:0]    segAll
);
    import lcm_pkg::*;

    logic [7:0] mem_reg [LCM_SEG_REGS];

    genvar g;
    generate
        for (g = 0; g < LCM_SEG_REGS; g++) begin : gSeg
            assign segAll[8*g +: 8] = mem_reg[g];
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    mem_reg[g] <= 8'h00;
                // R16 clear holds zero
                end else if (clearAll) begin
                    mem_reg[g] <= 8'h00;
                // R14 two pin nibbles
                end else if (wrEn && wrIdx == LCM_SEG_IDX_W'(g)) begin
                    mem_reg[g] <= wrData;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== verilog/lcm_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcm_ctrl (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // special function register access
    input  wire lcm_pkg::lcm_sfr_req_t         sfrReq,
    output logic [7:0]                         sfrRdata,
    // display clock source and divider select
    input  wire logic                          lfoClkIn,
    input  wire logic [1:0]                    displayClockDivider,
    // controls to the analog and display logic
    output lcm_pkg::lcm_ctrl_t                 ctrlOut,
    output logic                               displayClockGated,
    output logic                               displayClockDivided,
    output logic [8*lcm_pkg::LCM_SEG_REGS-1:0] segmentData
);
    import lcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    logic       pageHit;
    logic       hitContrast;
    logic       hitMaster;
    logic       hitSeg;
    logic [7:0] segOffset;
    assign pageHit     = (sfrReq.page == LCM_SFR_PAGE);
    // R3 register addresses
    assign hitContrast = pageHit && (sfrReq.addr == LCM_CONTRAST_ADDR);
    assign hitMaster   = pageHit && (sfrReq.addr == LCM_MASTER_ADDR);
    assign segOffset   = sfrReq.addr - LCM_SEG_BASE_ADDR;
    assign hitSeg      = pageHit && (sfrReq.addr >= LCM_SEG_BASE_ADDR)
                         && (segOffset < 8'(LCM_SEG_REGS));

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [4:0] contrast_reg;
    logic [4:0] contrast_next;
    logic [7:0] master_reg;
    logic [7:0] master_next;

    // R1 reserved bits dropped
    assign contrast_next = (sfrReq.wr && hitContrast) ? sfrReq.wdata[4:0] : contrast_reg;
    // R4 R17 reserved bits masked
    assign master_next   = (sfrReq.wr && hitMaster) ? (sfrReq.wdata & LCM_MASTER_MASK) : master_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            contrast_reg <= LCM_CONTRAST_RST;
            // R5 R7 R13 reset values
            master_reg   <= LCM_MASTER_RST;
        end else begin
            contrast_reg <= contrast_next;
            // R12 clear bit stays until rewritten
            master_reg   <= master_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // segment data
    logic segClear;
    // R11 clear on the writing edge
    assign segClear = master_next[LCM_MC_SEG_CLR];

    lcm_seg_mem uSegMem (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wrEn     (sfrReq.wr && hitSeg),
        .wrIdx    (segOffset[LCM_SEG_IDX_W-1:0]),
        .wrData   (sfrReq.wdata),
        .clearAll (segClear),
        .segAll   (segmentData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read back
    logic [7:0] rdSel;
    logic [7:0] segByte;
    logic [7:0] rdata_reg;
    assign segByte = segmentData[8*segOffset[LCM_SEG_IDX_W-1:0] +: 8];
    // R1 R4 reserved read zero
    assign rdSel = hitContrast ? {3'h0, contrast_reg} :
                   hitMaster   ? master_reg :
                   hitSeg      ? segByte : 8'h00;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (sfrReq.rd) begin
            rdata_reg <= rdSel;
        end
    end
    assign sfrRdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // control outputs
    lcm_ctrl_t ctrl_reg;
    lcm_ctrl_t ctrl_next;
    logic      biasEnNext;
    logic      convOeNext;

    assign biasEnNext = master_next[LCM_MC_BIAS_EN];
    assign convOeNext = master_next[LCM_MC_CONV_OE];
    assign ctrl_next  = '{
        // R2 setpoint code
        contrastCode:              contrast_next,
        // R8 shared generator
        biasGeneratorOn:           biasEnNext | convOeNext,
        // R5 bias enable
        displayBiasEnable:         biasEnNext,
        // R7 converter bias
        converterBiasOutputEnable: convOeNext,
        // R10 pump drive
        pumpReducedDrive:          master_next[LCM_MC_LOW_DRV],
        // R13 module enable
        displayModuleEnable:       master_next[LCM_MC_MOD_EN],
        segmentDataClear:          master_next[LCM_MC_SEG_CLR]
    };

    // outputs reset to the register reset values, so the converter keeps its bias through reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg.contrastCode              <= LCM_CONTRAST_RST;
            ctrl_reg.biasGeneratorOn           <= LCM_MASTER_RST[LCM_MC_BIAS_EN]
                                                  | LCM_MASTER_RST[LCM_MC_CONV_OE];
            ctrl_reg.displayBiasEnable         <= LCM_MASTER_RST[LCM_MC_BIAS_EN];
            ctrl_reg.converterBiasOutputEnable <= LCM_MASTER_RST[LCM_MC_CONV_OE];
            ctrl_reg.pumpReducedDrive          <= LCM_MASTER_RST[LCM_MC_LOW_DRV];
            ctrl_reg.displayModuleEnable       <= LCM_MASTER_RST[LCM_MC_MOD_EN];
            ctrl_reg.segmentDataClear          <= LCM_MASTER_RST[LCM_MC_SEG_CLR];
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end
    assign ctrlOut = ctrl_reg;

    ////////////////////////////////////////////////////////////////////////////
    // display clock gate and divider
    logic       gateOn;
    logic       gated_reg;
    logic       gatePrev_reg;
    logic       gateRise;
    logic       gateFall;
    logic [1:0] divCnt_reg;
    logic [1:0] divCnt_inc;
    logic [1:0] divCnt_next;
    logic       divided_reg;
    logic       divided_next;
    logic       divNow;
    logic       divKeepHigh;

    // R9 clock gate
    assign gateOn       = master_reg[LCM_MC_CLK_GATE];
    assign gateRise     = gated_reg && !gatePrev_reg;
    assign gateFall     = !gated_reg && gatePrev_reg;
    assign divCnt_inc   = divCnt_reg + 2'h1;
    // closing the gate restarts the divider, so a fresh enable begins on a rising edge
    assign divCnt_next  = !gateOn ? 2'h0 : (gateRise ? divCnt_inc : divCnt_reg);
    // R15 divide by 1, 2 or 4
    assign divNow       = (displayClockDivider == LCM_DIV2) ? (divCnt_reg[0] == 1'b0) :
                          (displayClockDivider == LCM_DIV4) ? (divCnt_reg == 2'h0) : 1'b1;
    // reserved code 11 behaves as divide by 1
    assign divKeepHigh  = ((displayClockDivider == LCM_DIV2) || (displayClockDivider == LCM_DIV4))
                          && divCnt_reg[0];
    assign divided_next = !gateOn              ? 1'b0 :
                          (gateRise && divNow) ? 1'b1 :
                          gateFall             ? (divKeepHigh && divided_reg) : divided_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gated_reg    <= 1'b0;
            gatePrev_reg <= 1'b0;
            divCnt_reg   <= 2'h0;
            divided_reg  <= 1'b0;
        end else begin
            gated_reg    <= lfoClkIn & gateOn;
            gatePrev_reg <= gated_reg;
            divCnt_reg   <= divCnt_next;
            divided_reg  <= divided_next;
        end
    end
    assign displayClockGated   = gated_reg;
    assign displayClockDivided = divided_reg;

endmodule
`default_nettype wire

// ==== verif/lcm_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcm_ctrl_monitor (
    // clock and reset
    input wire logic                               clk,
    input wire logic                               sys_rst,
    // watched ports
    input wire lcm_pkg::lcm_sfr_req_t              sfrReq,
    input wire logic [7:0]                         sfrRdata,
    input wire logic                               lfoClkIn,
    input wire logic [1:0]                         displayClockDivider,
    input wire lcm_pkg::lcm_ctrl_t                 ctrlOut,
    input wire logic                               displayClockGated,
    input wire logic                               displayClockDivided,
    input wire logic [8*lcm_pkg::LCM_SEG_REGS-1:0] segmentData
);
    import lcm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic pg  = sfrReq.page == LCM_SFR_PAGE;
    wire logic rdC = sfrReq.rd && pg && sfrReq.addr == LCM_CONTRAST_ADDR;
    wire logic rdM = sfrReq.rd && pg && sfrReq.addr == LCM_MASTER_ADDR;
    wire logic wrC = sfrReq.wr && pg && sfrReq.addr == LCM_CONTRAST_ADDR;
    wire logic wrM = sfrReq.wr && pg && sfrReq.addr == LCM_MASTER_ADDR;
    property p_cWr; wrC |=> ctrlOut.contrastCode == $past(sfrReq.wdata[4:0]); endproperty
    a_cWr: assert property (p_cWr) else $error("contrast code wrong");
    property p_cRd; rdC |=> sfrRdata == {3'h0, $past(ctrlOut.contrastCode)}; endproperty
    a_cRd: assert property (p_cRd) else $error("contrast read wrong");
    property p_mRd; rdM |=> sfrRdata[7] == 1'b0 && sfrRdata[3] == 1'b0; endproperty
    a_mRd: assert property (p_mRd) else $error("master reserved bits set");
    property p_mWr; wrM |=> {ctrlOut.displayBiasEnable, ctrlOut.converterBiasOutputEnable, ctrlOut.pumpReducedDrive,
        ctrlOut.segmentDataClear, ctrlOut.displayModuleEnable} == {$past(sfrReq.wdata[6:5]), $past(sfrReq.wdata[2:0])};
    endproperty
    a_mWr: assert property (p_mWr) else $error("master fields wrong");
    property p_bias; ctrlOut.biasGeneratorOn == (ctrlOut.displayBiasEnable | ctrlOut.converterBiasOutputEnable);
    endproperty
    a_bias: assert property (p_bias) else $error("bias generator state wrong");
    property p_gate; displayClockGated |-> $past(lfoClkIn); endproperty
    a_gate: assert property (p_gate) else $error("gated clock without source");
    property p_clr; ctrlOut.segmentDataClear |-> segmentData == '0; endproperty
    a_clr: assert property (p_clr) else $error("segments not held clear");
    property p_page; sfrReq.rd && !pg |=> sfrRdata == 8'h00; endproperty
    a_page: assert property (p_page) else $error("other page read not zero");
    property p_divFall; $fell(displayClockGated) && displayClockDivider == LCM_DIV1 |=> !displayClockDivided;
    endproperty
    a_divFall: assert property (p_divFall) else $error("undivided clock did not follow gated clock low");
endmodule
bind lcm_ctrl lcm_ctrl_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .lfoClkIn(lfoClkIn), .displayClockDivider(displayClockDivider), .ctrlOut(ctrlOut),
    .displayClockGated(displayClockGated), .displayClockDivided(displayClockDivided), .segmentData(segmentData));
`default_nettype wire

// ==== verif/lcm_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcm_ctrl_tb_top;
    import lcm_pkg::*;
    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    lcm_sfr_req_t sfrReq = '0;
    logic         lfoClkIn = 1'b0;
    logic [1:0]   displayClockDivider = 2'h0;
    logic [7:0]   sfrRdata;
    lcm_ctrl_t    ctrlOut;
    logic         displayClockGated;
    logic         displayClockDivided;
    logic [127:0] segmentData;
    logic [127:0] segModel = '0;
    logic         clrModel = 1'b0;
    int           failCount = 0;
    int           checksDone = 0;
    integer       seed = 31972;
    logic [7:0]   d;
    int           edges = 0;
    logic         divPrev = 1'b0;
    always #2 clk = ~clk;
    lcm_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .lfoClkIn(lfoClkIn),
        .displayClockDivider(displayClockDivider), .ctrlOut(ctrlOut), .displayClockGated(displayClockGated),
        .displayClockDivided(displayClockDivided), .segmentData(segmentData));
    function automatic logic [7:0] rd_exp(input logic [7:0] a, input logic [7:0] v);
        return (a == 8'h9C) ? (v & 8'h1F) : (a == 8'hAB) ? (v & 8'h77) : 8'h00;
    endfunction
    function automatic int div_edges(input int periods, input logic [1:0] code);
        return (code == LCM_DIV2) ? periods / 2 : (code == LCM_DIV4) ? periods / 4 : periods;
    endfunction
    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic sfr_wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfrReq <= '{page: p, addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(posedge clk);
        sfrReq.wr <= 1'b0;
        if (p == 8'h02 && a == 8'hAB) clrModel = v[1];
        if (clrModel) segModel = '0;
        else if (p == 8'h02 && a >= 8'h89 && a <= 8'h98) segModel[8*(a-8'h89) +: 8] = v;
        #1;
    endtask
    task automatic sfr_rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfrReq <= '{page: p, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        sfrReq.rd <= 1'b0;
        @(posedge clk);
        #1 check("sfrRdata", 128'(sfrRdata), 128'(e));
    endtask
    task automatic give_verdict();
        if (failCount == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #40000;
        failCount++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 check("rstCtrl", 128'({ctrlOut.converterBiasOutputEnable, ctrlOut.biasGeneratorOn,
            ctrlOut.contrastCode}), 128'({1'b1, 1'b1, LCM_CONTRAST_RST}));
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 check("convOe", 128'(ctrlOut.converterBiasOutputEnable), 128'h1);
        sfr_rd(8'h02, 8'h9C, 8'h00);
        sfr_rd(8'h02, 8'hAB, 8'h20);
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            sfr_wr(8'h02, 8'h9C, d);
            check("contrast", 128'(ctrlOut.contrastCode), 128'(d[4:0]));
            sfr_rd(8'h02, 8'h9C, rd_exp(8'h9C, d));
            sfr_wr(8'h02, 8'hAB, d);
            sfr_rd(8'h02, 8'hAB, rd_exp(8'hAB, d));
            check("master", 128'({ctrlOut.displayBiasEnable, ctrlOut.converterBiasOutputEnable,
                ctrlOut.pumpReducedDrive, ctrlOut.segmentDataClear, ctrlOut.displayModuleEnable}), 128'({d[6:5], d[2:0]}));
            check("biasOn", 128'(ctrlOut.biasGeneratorOn), 128'(d[6] | d[5]));
            sfr_wr(8'h02 + 8'(i % 2), 8'h89 + 8'(i % 16), ~d);
            check("segments", segmentData, segModel);
        end
        sfr_rd(8'h03, 8'h9C, 8'h00);
        sfr_rd(8'h02, 8'h9D, 8'h00);
        sfr_wr(8'h02, 8'hAB, 8'h00);
        for (int i = 0; i < 16; i++) sfr_wr(8'h02, 8'h89 + 8'(i), 8'($random(seed)) | 8'h01);
        check("segments", segmentData, segModel);
        for (int k = 0; k < 16; k++) sfr_rd(8'h02, 8'h89 + 8'(k), segModel[8*k +: 8]);
        sfr_wr(8'h02, 8'hAB, 8'h02);
        check("segments", segmentData, 128'h0);
        sfr_rd(8'h02, 8'hAB, 8'h02);
        for (int g = 0; g < 2; g++) begin
            sfr_wr(8'h02, 8'hAB, 8'(g) << 4);
            for (int k = 0; k < 12; k++) begin
                @(posedge clk);
                d = 8'($random(seed));
                lfoClkIn <= d[0];
                displayClockDivider <= d[2:1];
                @(posedge clk);
                #1 check("gated", 128'(displayClockGated), 128'(d[0] & g[0]));
            end
        end
        for (int c = 0; c < 3; c++) begin
            @(posedge clk);
            lfoClkIn <= 1'b0;
            displayClockDivider <= 2'(c);
            sfr_wr(8'h02, 8'hAB, 8'h00);
            sfr_wr(8'h02, 8'hAB, 8'h10);
            edges = 0;
            divPrev = 1'b0;
            for (int k = 0; k < 36; k++) begin
                @(posedge clk);
                lfoClkIn <= (k < 32) && k[1];
                #1 if (displayClockDivided === 1'b1 && divPrev === 1'b0) edges++;
                divPrev = displayClockDivided;
            end
            check("divEdges", 128'(edges), 128'(div_edges(8, 2'(c))));
        end
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("rstMid", 128'({ctrlOut.converterBiasOutputEnable, ctrlOut.biasGeneratorOn,
            ctrlOut.contrastCode}), 128'({1'b1, 1'b1, LCM_CONTRAST_RST}));
        @(posedge clk);
        sys_rst <= 1'b0;
        sfr_rd(8'h02, 8'h9C, 8'h00);
        sfr_rd(8'h02, 8'hAB, 8'h20);
        give_verdict();
    end
endmodule
`default_nettype wire
